// >>> rtl/scs_spi_channel.sv
module scs_spi_channel (
  // Clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  resetn_i,
  // Register port
  input  wire logic [5:0]            reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic [31:0]                reg_rdata_o,
  // Serial pins
  input  wire scs_pkg::scs_pin_in_s  pin_i,
  output scs_pkg::scs_pin_out_s      pin_o,
  // Event pulses
  output logic                       tx_request_irq_o,
  output logic                       rx_done_irq_o,
  output logic                       frame_end_irq_o,
  output logic                       error_irq_o
);
  import scs_pkg::*;

  scs_state_e   state_q, state_d;
  scs_role_s    role_q;
  scs_check_s   check_q;
  scs_chcfg_s   chcfg_q;
  scs_pin_in_s  sync1_q, sync2_q;
  scs_pin_out_s pin_q;
  logic         en_q, sck_prev_q, tx_full_q, crc_err_q;
  logic [5:0]   frame_bit_length_q, edge_q;
  logic [7:0]   frame_count_setting_q, frames_q, gap_q;
  logic [11:0]  baud_q, div_q;
  logic [4:0]   bit_q;
  logic [31:0]  transmit_data_register_q, receive_data_register_q, tx_sh_q, rx_sh_q, rdata_q;
  logic [3:0]   intf_q;
  logic         txp_q, rxp_q, fep_q, errp_q;

  // Register write decode
  wire wr_en    = reg_wr_i && reg_addr_i == OFF_ENABLE;
  wire wr_role  = reg_wr_i && reg_addr_i == OFF_ROLE;
  wire wr_check = reg_wr_i && reg_addr_i == OFF_CHECK;
  wire wr_chcfg = reg_wr_i && reg_addr_i == OFF_CHCFG;
  wire wr_frame_bit_length  = reg_wr_i && reg_addr_i == OFF_FRAME_BIT_LENGTH;
  wire wr_frame_count_setting = reg_wr_i && reg_addr_i == OFF_FRAME_COUNT_SETTING;
  wire wr_baud  = reg_wr_i && reg_addr_i == OFF_BAUD;
  wire wr_transmit_data_register  = reg_wr_i && reg_addr_i == OFF_TRANSMIT_DATA_REGISTER;
  wire wr_intf  = reg_wr_i && reg_addr_i == OFF_INTF;
  wire wr_stat  = reg_wr_i && reg_addr_i == OFF_STATUS;

  // Role and mode selection
  wire       master  = ~role_q.role_select;
  wire       crc_on  = chcfg_q.crc_enable && chcfg_q.crc_format_select;
  wire [4:0] frame_bit_length_m1 = frame_bit_length_q[4:0] - 5'h01;  // 0x20 and 0 both mean 32
  wire       shifting = state_q == ST_SHIFT;

  // Loopback feeds our own data out back to the receiver
  wire sdi = check_q.loopback_enable ? pin_q.sdo : sync2_q.sdi;

  // Master clock generation
  wire tick    = div_q == 12'h000;
  wire m_lead  = master && shifting && tick && !edge_q[0];
  wire m_trail = master && shifting && tick && edge_q[0];
  wire m_last  = m_trail && edge_q == {frame_bit_length_m1, 1'b1};

  // Slave edges from the synchronised link clock
  wire s_edge  = sync2_q.sck ^ sck_prev_q;
  wire s_lead  = !master && shifting && s_edge
                 && sync2_q.sck != role_q.idle_clock_level;
  wire s_trail = !master && shifting && s_edge
                 && sync2_q.sck == role_q.idle_clock_level;
  wire s_last  = s_lead && bit_q == frame_bit_length_m1;
  wire cs_act  = role_q.cs_input_recognition ? !sync2_q.cs_n : 1'b1;

  // Sampling point, one edge later when late sampling is chosen in master role; slave always samples on the leading edge
  wire sample    = master ? (role_q.late_sample_select ? m_trail
                                                       : m_lead)
                          : s_lead;
  wire shift_out = master ? (m_trail && !m_last) : s_trail;
  wire done      = m_last || s_last;

  // Frame starts: master on a written word, slave on chip select, or at once when cs input recognition is off
  wire start_m = en_q && master && state_q == ST_IDLE && tx_full_q;
  wire start_s = en_q && !master && state_q == ST_IDLE && cs_act;
  wire load    = start_m || start_s;

  // Transmit word with the CRC replacing the low bits
  wire [2:0]  tx_crc  = scs_crc3({transmit_data_register_q[31:3], 3'h0});
  wire [31:0] tx_prot = crc_on ? {transmit_data_register_q[31:3], tx_crc}
                               : transmit_data_register_q;
  wire [31:0] tx_word = chcfg_q.transmit_enable ? tx_prot : 32'h0;
  wire [31:0] tx_nx   = {tx_sh_q[30:0], 1'b0};

  // Receive word including a sample taken on the final edge
  wire [31:0] rx_sh_d = sample ? {rx_sh_q[30:0], sdi} : rx_sh_q;
  wire [2:0]  rx_crc  = scs_crc3(rx_sh_d);
  wire crc_fail   = done && chcfg_q.receive_enable && crc_on
                    && rx_crc != CRC_TARGET;
  wire last_frame = frames_q + 8'h01 == frame_count_setting_q;
  wire rx_ev      = done && chcfg_q.receive_enable;
  wire tx_ev      = done && !last_frame;
  wire fe_ev      = done && last_frame;
  wire [3:0] intf_set = {crc_fail, fe_ev, rx_ev, tx_ev};
  wire cs_drive   = state_d == ST_SHIFT && master;

  // Sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (load) begin
          state_d = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (done) begin
          state_d = ST_GAP;
        end else if (!master && !cs_act) begin
          state_d = ST_IDLE;  // Aborted by the outside master
        end
      end
      ST_GAP: begin
        if (master ? gap_q == 8'h00
                   : (!cs_act || !role_q.cs_input_recognition)) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (!en_q) begin
      state_d = ST_IDLE;
    end
  end

  // Read multiplexer, unmapped offsets read zero
  logic [31:0] rd_val;
  always_comb begin
    case (reg_addr_i)
      OFF_ENABLE: rd_val = {31'h0, en_q};
      OFF_ROLE:   rd_val = {26'h0, role_q};
      OFF_CHECK:  rd_val = {30'h0, check_q};
      OFF_CHCFG:  rd_val = {28'h0, chcfg_q};
      OFF_FRAME_BIT_LENGTH:   rd_val = {26'h0, frame_bit_length_q};
      OFF_FRAME_COUNT_SETTING:  rd_val = {24'h0, frame_count_setting_q};
      OFF_BAUD:   rd_val = {20'h0, baud_q};
      OFF_TRANSMIT_DATA_REGISTER:   rd_val = transmit_data_register_q;
      OFF_RECEIVE_DATA_REGISTER:   rd_val = receive_data_register_q;
      OFF_INTF:   rd_val = {28'h0, intf_q};
      OFF_STATUS: rd_val = {16'h0, frames_q, 5'h0, tx_full_q,
                            shifting, crc_err_q};
      default:    rd_val = 32'h0;
    endcase
  end

  // Pin synchroniser, second stage is the only reader of the first
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_q    <= '{sck: 1'b0, sdi: 1'b0, cs_n: 1'b1};
      sync2_q    <= '{sck: 1'b0, sdi: 1'b0, cs_n: 1'b1};
      sck_prev_q <= 1'b0;
    end else begin
      sync1_q    <= pin_i;
      sync2_q    <= sync1_q;
      sck_prev_q <= sync2_q.sck;
    end
  end

  // Configuration registers
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_q    <= 1'b0;
      role_q  <= '0;
      check_q <= '0;
      chcfg_q <= '0;
      frame_bit_length_q  <= FRAME_BIT_LENGTH_RST;
      frame_count_setting_q <= FRAME_COUNT_SETTING_RST;
      baud_q  <= BAUD_RST;
    end else begin
      if (wr_en)    en_q    <= reg_wdata_i[0];
      if (wr_role)  role_q  <= scs_role_s'(reg_wdata_i[5:0]);
      if (wr_check) check_q <= scs_check_s'(reg_wdata_i[1:0]);
      if (wr_chcfg) chcfg_q <= scs_chcfg_s'(reg_wdata_i[3:0]);
      if (wr_frame_bit_length)  frame_bit_length_q  <= reg_wdata_i[5:0];
      if (wr_frame_count_setting) frame_count_setting_q <= reg_wdata_i[7:0];
      if (wr_baud)  baud_q  <= reg_wdata_i[11:0];
    end
  end

  // Data registers and sticky flags; a new event beats a clear
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      transmit_data_register_q    <= 32'h0;
      receive_data_register_q    <= 32'h0;
      tx_full_q <= 1'b0;
      intf_q    <= 4'h0;
      crc_err_q <= 1'b0;
      rdata_q   <= 32'h0;
    end else begin
      if (wr_transmit_data_register) transmit_data_register_q <= reg_wdata_i;
      if (rx_ev)   receive_data_register_q <= rx_sh_d;
      tx_full_q <= wr_transmit_data_register || (tx_full_q && !load);
      intf_q    <= (intf_q & ~(wr_intf ? reg_wdata_i[3:0] : 4'h0))
                   | intf_set;
      crc_err_q <= crc_fail
                   || (crc_err_q && !(wr_stat && reg_wdata_i[0]));
      rdata_q   <= reg_rd_i ? rd_val : 32'h0;
    end
  end

  // Frame engine counters and shifters
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q  <= ST_IDLE;
      div_q    <= BAUD_RST;
      edge_q   <= 6'h00;
      bit_q    <= 5'h00;
      gap_q    <= GAP_RST;
      frames_q <= 8'h00;
      tx_sh_q  <= 32'h0;
      rx_sh_q  <= 32'h0;
    end else begin
      state_q  <= state_d;
      div_q    <= (shifting && !tick) ? div_q - 12'h001 : baud_q;
      edge_q   <= load ? 6'h00 : (m_lead || m_trail) ? edge_q + 6'h01
                                                      : edge_q;
      bit_q    <= load ? 5'h00 : s_lead ? bit_q + 5'h01 : bit_q;
      gap_q    <= done ? GAP_RST - 8'h01
                : (state_q == ST_GAP) ? gap_q - 8'h01 : gap_q;
      frames_q <= !en_q ? 8'h00 : fe_ev ? 8'h00
                : done ? frames_q + 8'h01 : frames_q;
      tx_sh_q  <= load ? tx_word : shift_out ? tx_nx : tx_sh_q;
      rx_sh_q  <= load ? 32'h0 : rx_sh_d;
    end
  end

  // Pin drivers, all registered
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_q <= '{sck: 1'b0, sck_oe_n: 1'b1, sdo: 1'b0,
                 sdo_oe_n: 1'b1, cs: 1'b1};
    end else begin
      pin_q.sck      <= (master && shifting && tick) ? ~pin_q.sck
                      : shifting ? pin_q.sck
                      : role_q.idle_clock_level;
      pin_q.sck_oe_n <= !(en_q && master);
      pin_q.sdo      <= (wr_en && reg_wdata_i[0] && !en_q) ? 1'b0
                      : load ? tx_word[frame_bit_length_m1]
                      : shift_out ? tx_nx[frame_bit_length_m1] : pin_q.sdo;
      pin_q.sdo_oe_n <= !(en_q && (master || cs_act));
      pin_q.cs       <= role_q.chip_select_polarity ? cs_drive
                                                    : !cs_drive;
    end
  end

  // Event pulses, one cycle each
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      txp_q  <= 1'b0;
      rxp_q  <= 1'b0;
      fep_q  <= 1'b0;
      errp_q <= 1'b0;
    end else begin
      txp_q  <= tx_ev;
      rxp_q  <= rx_ev;
      fep_q  <= fe_ev;
      errp_q <= crc_fail;
    end
  end

  assign reg_rdata_o      = rdata_q;
  assign pin_o            = pin_q;
  assign tx_request_irq_o = txp_q;
  assign rx_done_irq_o    = rxp_q;
  assign frame_end_irq_o  = fep_q;
  assign error_irq_o      = errp_q;

  // Helper: cycles spent in one master frame
  logic [15:0] shift_cyc_q;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) shift_cyc_q <= 16'h0;
    else shift_cyc_q <= shifting ? shift_cyc_q + 16'h1 : 16'h0;
  end

  chk_crc_insert: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (start_m && crc_on && chcfg_q.transmit_enable) |=>
      tx_sh_q[2:0] == scs_crc3({$past(transmit_data_register_q[31:3]), 3'h0}))
    else $error("CRC not placed in low transmit bits");

  chk_crc_error_flag: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    crc_fail |=> (error_irq_o && crc_err_q && intf_q[INTF_ERR])
                 ##1 !error_irq_o)
    else $error("CRC mismatch not reported");

  chk_rx_flag_set: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    rx_ev |=> intf_q[INTF_RX] && rx_done_irq_o
              && receive_data_register_q == $past(rx_sh_d))
    else $error("Receive event not latched");

  chk_frame_end: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    fe_ev |=> frame_end_irq_o && frames_q == 8'h00
              && !tx_request_irq_o)
    else $error("Frame end not raised on last frame");

  chk_idle_clock: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (master && en_q && state_q == ST_IDLE && $past(state_q) == ST_IDLE)
      |-> pin_o.sck == role_q.idle_clock_level)
    else $error("Serial clock not at idle level");

  chk_cs_polarity: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (master && shifting && !role_q.chip_select_polarity)
      |-> !pin_o.cs)
    else $error("Chip select not active low in frame");

  chk_start_on_write: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (wr_transmit_data_register && master && en_q && state_q == ST_IDLE && !wr_en)
      |-> ##2 state_q == ST_SHIFT)
    else $error("Master did not start after data write");

  chk_frame_time: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    m_last |-> shift_cyc_q + 16'h1 ==
      (16'({frame_bit_length_m1, 1'b1}) + 16'h1) * (16'(baud_q) + 16'h1))
    else $error("Master frame length or rate wrong");

  chk_sdo_low_on_enable: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (wr_en && reg_wdata_i[0] && !en_q) |=> !pin_o.sdo)
    else $error("Data out not low after enable");
endmodule

// >>> rtl/scs_pkg.sv
package scs_pkg;
  // Operation
  // - Insert three-bit CRC over bits 31..3 on transmit
  // - Check received bits 31..3 against carried CRC
  // - CRC mismatch raises error pulse and flag
  // - Poly x^3+x+1, start 101, target 000
  // - Frame length setting 0x20 gives 32 bits
  // - Frame count setting sets frames per set
  // - CRC enable and format chosen per channel
  // - Without CRC all written bits pass unchanged
  // - One transmit and one receive data register
  // - Master starts frame on transmit data write
  // - Last frame of set raises frame-end event
  // - Event causes latched in readable flag register
  // - Master generates serial clock at programmed rate
  // - Late sample takes data one edge later in master role only
  // - Idle clock level held between transfers
  // - Data out low after enable, then holds
  // - Chip-select polarity zero means active low
  // - Consistency check and loopback off when zero
  // - Unit enable bit switches whole unit on

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [5:0] OFF_ENABLE = 6'h00;
  localparam logic [5:0] OFF_ROLE   = 6'h04;
  localparam logic [5:0] OFF_CHECK  = 6'h08;
  localparam logic [5:0] OFF_CHCFG  = 6'h0C;
  localparam logic [5:0] OFF_FRAME_BIT_LENGTH   = 6'h10;
  localparam logic [5:0] OFF_FRAME_COUNT_SETTING  = 6'h14;
  localparam logic [5:0] OFF_BAUD   = 6'h18;
  localparam logic [5:0] OFF_TRANSMIT_DATA_REGISTER   = 6'h1C;
  localparam logic [5:0] OFF_RECEIVE_DATA_REGISTER   = 6'h20;
  localparam logic [5:0] OFF_INTF   = 6'h24;
  localparam logic [5:0] OFF_STATUS = 6'h28;

  // Interrupt flag bit positions
  localparam int unsigned INTF_TX  = 0;
  localparam int unsigned INTF_RX  = 1;
  localparam int unsigned INTF_FE  = 2;
  localparam int unsigned INTF_ERR = 3;

  // Reset values and timing
  localparam logic [5:0]  FRAME_BIT_LENGTH_RST  = 6'h20;
  localparam logic [7:0]  FRAME_COUNT_SETTING_RST = 8'h04;
  localparam int unsigned MCLK_HZ   = 250_000_000;
  localparam int unsigned SCK_HZ    = 10_000_000;
  localparam int unsigned HALF_CYC  =
    (MCLK_HZ + 2 * SCK_HZ - 1) / (2 * SCK_HZ);
  localparam logic [11:0] BAUD_RST  = 12'(HALF_CYC - 1);
  localparam logic [7:0]  GAP_RST   = 8'h08;

  // CRC constants
  localparam logic [2:0] CRC_POLY   = 3'h5;
  localparam logic [2:0] CRC_TAPS   = {CRC_POLY[1:0], 1'b1};
  localparam logic [2:0] CRC_INIT   = 3'h5;
  localparam logic [2:0] CRC_TARGET = 3'h0;

  typedef struct packed {
    logic role_select;
    logic cs_input_recognition;
    logic late_sample_select;
    logic idle_clock_level;
    logic output_idle_level;
    logic chip_select_polarity;
  } scs_role_s;

  typedef struct packed {
    logic consistency_check_enable;
    logic loopback_enable;
  } scs_check_s;

  typedef struct packed {
    logic crc_format_select;
    logic crc_enable;
    logic receive_enable;
    logic transmit_enable;
  } scs_chcfg_s;

  typedef struct packed {
    logic sck;
    logic sdi;
    logic cs_n;
  } scs_pin_in_s;

  typedef struct packed {
    logic sck;
    logic sck_oe_n;
    logic sdo;
    logic sdo_oe_n;
    logic cs;
  } scs_pin_out_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_GAP   = 3'b100
  } scs_state_e;

  // Bits enter at the low end, so a zeroed tail yields the check field
  // and an intact received word leaves the target value behind
  function automatic logic [2:0] scs_crc3(input logic [31:0] w);
    logic [2:0] c;
    c = CRC_INIT;
    for (int i = 31; i >= 0; i--) begin
      c = {c[1:0], w[i]} ^ (c[2] ? CRC_TAPS : 3'h0);
    end
    return c;
  endfunction
endpackage

// >>> sim/scs_slave_model.sv
module scs_slave_model (
  // Link from the channel
  input  wire logic        sck_i,
  input  wire logic        mosi_i,
  input  wire logic        cs_i,
  // Word returned, word captured
  input  wire logic [31:0] tx_word_i,
  output logic             miso_o,
  output logic [31:0]      rx_word_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned bit_ix;
  logic [31:0] shift_q;
  initial begin
    miso_o = 1'b0;
  end
  // Frame opens: MSB is on the line at once
  always @(negedge cs_i) begin
    bit_ix = 31;
    shift_q = '0;
    miso_o = tx_word_i[31];
  end
  // Leading edge takes a bit, MSB first
  always @(posedge sck_i) begin
    if (!cs_i) shift_q = {shift_q[30:0], mosi_i};
  end
  // Trailing edge moves on to the next bit
  always @(negedge sck_i) begin
    if (!cs_i && bit_ix > 0) begin
      bit_ix--;
      miso_o = tx_word_i[bit_ix];
    end
  end
  // Released line shows the inverse so a stale bit is never read
  always @(posedge cs_i) begin
    rx_word_o = shift_q;
    miso_o = ~miso_o;
  end
endmodule

// >>> sim/scs_spi_channel_bench.sv
module scs_spi_channel_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import scs_pkg::*;
  localparam logic [31:0] WR_W [4] = '{32'h0000_0004, 32'hFFFF_FFFF,
                                       32'h0F0F_0F0D, 32'h0FF2_C8F9};
  localparam logic [31:0] CRC_W [4] = '{32'h0000_0003, 32'hFFFF_FFF8,
                                        32'h0F0F_0F0A, 32'h0FF2_C8FE};
  localparam logic [31:0] SW = 32'h3C5A_96E1;
  logic         mclk_i, resetn_i, reg_wr_i, reg_rd_i;
  logic [5:0]   reg_addr_i;
  logic [31:0]  reg_wdata_i, reg_rdata_o, sl_tx, sl_rx, rd_v;
  scs_pin_in_s  pin_i;
  scs_pin_out_s pin_o;
  logic         txq_o, rxd_o, fe_o, err_o;
  logic         bm_on, bm_sck, bm_sdi, bm_csn, sl_sdi;
  int           n_mismatch, checked, cyc, n_rise, hi_cnt, hi_last;
  int           n_txq, n_rxd, n_fe, n_err;
  // Bench owns the data input only in slave role; the sck and cs_n inputs always come from the bench
  assign pin_i = {bm_sck, bm_on ? bm_sdi : sl_sdi, bm_csn};
  scs_spi_channel dut_u (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pin_i(pin_i), .pin_o(pin_o),
    .tx_request_irq_o(txq_o), .rx_done_irq_o(rxd_o),
    .frame_end_irq_o(fe_o), .error_irq_o(err_o));
  scs_slave_model slave_u (
    .sck_i(pin_o.sck), .mosi_i(pin_o.sdo), .cs_i(pin_o.cs),
    .tx_word_i(sl_tx), .miso_o(sl_sdi), .rx_word_o(sl_rx));
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  // Pulse counts, clock high time, edge count, hang guard
  always @(posedge mclk_i) begin
    if (pin_o.sck === 1'b1) begin
      if (hi_cnt == 0) n_rise++;
      hi_cnt++;
    end else if (hi_cnt != 0) begin
      hi_last = hi_cnt;
      hi_cnt = 0;
    end
    if (txq_o === 1'b1) n_txq++;
    if (rxd_o === 1'b1) n_rxd++;
    if (fe_o === 1'b1) n_fe++;
    if (err_o === 1'b1) n_err++;
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      $display("Error timeout reached");
      print_verdict();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, ex);
    checked++;
    if (seen !== ex) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic reg_wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // Bounded wait for the chip select to reach a level
  task automatic wait_cs(input logic lvl, input int lim);
    int i;
    i = 0;
    while (pin_o.cs !== lvl && i < lim) begin
      @(posedge mclk_i);
      #1 i++;
    end
  endtask
  // One master frame: software writes, then reads back once chip select has returned high
  task automatic master_frame(input logic [31:0] wr, ex, sw);
    sl_tx = sw;
    n_rise = 0;
    reg_wr(OFF_TRANSMIT_DATA_REGISTER, wr);
    wait_cs(1'b0, 4);
    check("cs active", 32'(pin_o.cs), 32'h0);
    check("sdo enabled", 32'(pin_o.sdo_oe_n), 32'h0);
    wait_cs(1'b1, 1200);
    repeat (10) @(posedge mclk_i);
    #1 check("sck idle", 32'(pin_o.sck), 32'h0);
    check("bits in frame", 32'(n_rise), 32'h20);
    check("sck half period", 32'(hi_last), 32'(BAUD_RST) + 1);
    check("word sent", sl_rx, ex);
    reg_rd(OFF_RECEIVE_DATA_REGISTER, rd_v);
    check("word received", rd_v, sw);
  endtask
  task automatic test_reset();
    @(posedge mclk_i);
    #1 check("cs after reset", 32'(pin_o.cs), 32'h1);
    check("sck oe after reset", 32'(pin_o.sck_oe_n), 32'h1);
    reg_rd(OFF_FRAME_BIT_LENGTH, rd_v);
    check("length reset", rd_v, 32'(FRAME_BIT_LENGTH_RST));
    reg_rd(OFF_FRAME_COUNT_SETTING, rd_v);
    check("count reset", rd_v, 32'(FRAME_COUNT_SETTING_RST));
    reg_rd(OFF_BAUD, rd_v);
    check("rate reset", rd_v, 32'(BAUD_RST));
    reg_rd(6'h3C, rd_v);
    check("unmapped read", rd_v, 32'h0);
    // Master, late sample, no recognition of cs input
    reg_wr(OFF_ROLE, 32'h0000_0008);
    reg_wr(OFF_CHECK, 32'h0);
    reg_wr(OFF_ENABLE, 32'h1);
    repeat (3) @(posedge mclk_i);
    #1 check("sdo low on enable", 32'(pin_o.sdo), 32'h0);
    check("sck driven", 32'(pin_o.sck_oe_n), 32'h0);
    $display("Test reset done");
  endtask
  task automatic test_crc_set();
    reg_wr(OFF_CHCFG, 32'h0000_000F);
    {n_txq, n_rxd, n_fe, n_err} = '0;
    for (int k = 0; k < 4; k++) master_frame(WR_W[k], CRC_W[k], CRC_W[k]);
    check("tx requests", 32'(n_txq), 32'h3);
    check("frame ends", 32'(n_fe), 32'h1);
    check("rx events", 32'(n_rxd), 32'h4);
    check("no crc error", 32'(n_err), 32'h0);
    reg_rd(OFF_INTF, rd_v);
    check("flags latched", rd_v, 32'h7);
    reg_wr(OFF_INTF, 32'hF);
    reg_rd(OFF_INTF, rd_v);
    check("flags cleared", rd_v, 32'h0);
    $display("Test crc set done");
  endtask
  // Second set, first frame arrives with a broken check field
  task automatic test_err_set();
    {n_fe, n_err} = '0;
    master_frame(WR_W[0], CRC_W[0], 32'h0000_0004);
    for (int k = 1; k < 4; k++) master_frame(WR_W[k], CRC_W[k], CRC_W[k]);
    check("error pulses", 32'(n_err), 32'h1);
    check("second set ends", 32'(n_fe), 32'h1);
    reg_rd(OFF_STATUS, rd_v);
    check("crc error flag", 32'(rd_v[0]), 32'h1);
    reg_rd(OFF_INTF, rd_v);
    check("error flag", 32'(rd_v[INTF_ERR]), 32'h1);
    $display("Test error set done");
  endtask
  task automatic test_plain();
    reg_wr(OFF_CHCFG, 32'h0000_0003);
    master_frame(32'h1234_5677, 32'h1234_5677, 32'h89AB_CDEF);
    // In-frame format is not built, so the word passes unchanged
    reg_wr(OFF_CHCFG, 32'h0000_0007);
    // Standard sampling point on the leading edge
    reg_wr(OFF_ROLE, 32'h0);
    master_frame(32'h5A5A_A5A5, 32'h5A5A_A5A5, 32'h0123_4567);
    $display("Test plain frame done");
  endtask
  // Slave role, link clock from the bench at its own phase
  task automatic test_slave();
    logic [31:0] got;
    reg_wr(OFF_ENABLE, 32'h0);
    reg_wr(OFF_ROLE, 32'h0000_0030);
    reg_wr(OFF_ENABLE, 32'h1);
    reg_wr(OFF_TRANSMIT_DATA_REGISTER, 32'hA5C3_0F96);
    n_rxd = 0;
    @(posedge mclk_i);
    bm_on <= 1'b1;
    #1.3 bm_csn = 1'b0;
    bm_sdi = SW[31];
    for (int i = 31; i >= 0; i--) begin
      #80 bm_sck = 1'b1;
      got[i] = pin_o.sdo;
      #80 bm_sck = 1'b0;
      if (i > 0) bm_sdi = SW[i-1];
    end
    #80 bm_csn = 1'b1;
    bm_sdi = ~bm_sdi;
    repeat (10) @(posedge mclk_i);
    check("slave word sent", got, 32'hA5C3_0F96);
    check("slave rx event", 32'(n_rxd), 32'h1);
    reg_rd(OFF_RECEIVE_DATA_REGISTER, rd_v);
    check("slave word received", rd_v, SW);
    $display("Test slave role done");
  endtask
  task automatic print_verdict();
    $display("Counts: checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    resetn_i = 1'b0;
    {reg_wr_i, reg_rd_i, bm_on, bm_sck, bm_sdi} = '0;
    bm_csn = 1'b1;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    sl_tx = '0;
    repeat (10) @(posedge mclk_i);
    resetn_i <= 1'b1;
    test_reset();
    test_crc_set();
    test_err_set();
    test_plain();
    test_slave();
    print_verdict();
  end
endmodule
